// file: rtl/down_timer_pkg.sv
// Notes on behaviour
// - firmware pause freezes count, resume from held value
// - debug pause enable gates debug freeze input
// - run request write to a stopped counter loads start value, counts
// - zero start value: no start, run clears
// - run request zero stops, clears count, no irq
// - one-shot expiry clears run request bit
// - periodic reload restarts; one-shot stops at zero
// - enable clear resets all register bits
// - soft interrupt write one raises that interrupt
// - soft interrupt zero ignored, reads zero
// - expiry irq on one-to-zero step, even when a count write replaces that step
// - counter 32 bits, read/write, resets zero
// - new start value used only at reload or at a run request write that starts the count
// - all logic on the 32 kHz core clock
package down_timer_pkg;
    localparam logic [3:0] count_offset    = 4'h0;
    localparam logic [3:0] start_offset    = 4'h4;
    localparam logic [3:0] control_offset  = 4'h8;
    localparam logic [3:0] soft_irq_offset = 4'hC;
    localparam int         ctl_enable_bit  = 0;
    localparam int         ctl_reload_bit  = 1;
    localparam int         ctl_run_bit     = 2;
    localparam int         ctl_debug_bit   = 3;
    localparam int         ctl_pause_bit   = 4;
    localparam int         soft_irq_count  = 4;
    localparam logic [31:0] word_zero      = 32'h0000_0000;
    localparam logic [31:0] word_one       = 32'h0000_0001;
    localparam logic [4:0]  control_reset  = 5'h00;
    localparam logic [1:0]  resp_okay      = 2'h0;
    localparam logic [1:0]  resp_slverr    = 2'h2;

    typedef struct packed {
        logic pause;
        logic debug_pause_enable;
        logic run;
        logic reload;
        logic enable;
    } control_t;
endpackage

// file: rtl/down_timer.sv
`timescale 1ns/1ps
module down_timer
    import down_timer_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        debug_freeze,
    output logic             expiry_irq,
    output logic [3:0]       soft_irq
);
    // aclk is the 32 kHz core clock
    logic [3:0]  aw_addr_reg;
    logic        aw_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_full_reg;
    logic        freeze_meta_reg;
    logic        freeze_sync_reg;
    logic [31:0] count_reg;
    logic [31:0] start_reg;
    control_t    ctl_reg;
    logic        wr_go;
    logic        frozen;
    logic        ticking;
    logic        expire;
    logic [31:0] wmask;
    logic [31:0] wr_count;
    logic [31:0] wr_ctl;
    logic        ctl_write;
    logic        run_write;
    logic        resume;

    assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mask
            assign wmask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
        end
    endgenerate
    assign wr_count = (count_reg & ~wmask) | (w_data_reg & wmask);
    assign wr_ctl   = w_data_reg & wmask;
    assign frozen   = ctl_reg.pause
                      || (ctl_reg.debug_pause_enable && freeze_sync_reg);
    assign ticking  = ctl_reg.enable && ctl_reg.run && !frozen;
    assign expire   = ticking && count_reg == word_one;
    assign ctl_write = wr_go && aw_addr_reg == control_offset && w_strb_reg[0];
    assign run_write = wr_ctl[ctl_run_bit] && wr_ctl[ctl_enable_bit];
    // a run write to a running counter keeps its value, so clearing pause resumes it
    assign resume    = ctl_write && run_write && ctl_reg.run;

    // write address and data are held until both are present
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg   <= 1'b0;
            aw_addr_reg   <= 4'h0;
            s_axi_awready <= 1'b0;
        end
        else if (wr_go)
        begin
            aw_full_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_full_reg && !s_axi_awready;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_reg   <= 1'b0;
            w_data_reg   <= word_zero;
            w_strb_reg   <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (wr_go)
        begin
            w_full_reg   <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_full_reg && !s_axi_wready;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg[1:0] == 2'h0) ? resp_okay : resp_slverr;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= word_zero;
            s_axi_rresp   <= resp_okay;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= resp_okay;
            case (s_axi_araddr)
                count_offset:    s_axi_rdata <= count_reg;
                start_offset:    s_axi_rdata <= start_reg;
                control_offset:  s_axi_rdata <= {27'h0000000, ctl_reg};
                soft_irq_offset: s_axi_rdata <= word_zero;
                default:
                begin
                    s_axi_rdata <= word_zero;
                    s_axi_rresp <= resp_slverr;
                end
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
        else
        begin
            s_axi_arready <= !s_axi_arready;
        end
    end

    // debug freeze comes from another part of the chip
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            freeze_meta_reg <= 1'b0;
            freeze_sync_reg <= 1'b0;
        end
        else
        begin
            freeze_meta_reg <= debug_freeze;
            freeze_sync_reg <= freeze_meta_reg;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_reg <= word_zero;
        end
        else if (!ctl_reg.enable)
        begin
            start_reg <= word_zero;
        end
        else if (wr_go && aw_addr_reg == start_offset)
        begin
            start_reg <= (start_reg & ~wmask) | (w_data_reg & wmask);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_reg <= control_t'(control_reset);
        end
        else if (ctl_write)
        begin
            ctl_reg.enable             <= wr_ctl[ctl_enable_bit];
            ctl_reg.reload             <= wr_ctl[ctl_reload_bit] && wr_ctl[ctl_enable_bit];
            ctl_reg.debug_pause_enable <= wr_ctl[ctl_debug_bit] && wr_ctl[ctl_enable_bit];
            ctl_reg.pause              <= wr_ctl[ctl_pause_bit] && wr_ctl[ctl_enable_bit];
            ctl_reg.run                <= run_write
                                          && (resume ? !(expire && !ctl_reg.reload)
                                                     : start_reg != word_zero);
        end
        else if (!ctl_reg.enable)
        begin
            ctl_reg <= control_t'(control_reset);
        end
        else if (expire && !ctl_reg.reload)
        begin
            ctl_reg.run <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_reg <= word_zero;
        end
        else if (ctl_write && !resume)
        begin
            if (run_write)
            begin
                count_reg <= start_reg;
            end
            else
            begin
                count_reg <= word_zero;
            end
        end
        else if (!ctl_reg.enable)
        begin
            count_reg <= word_zero;
        end
        else if (wr_go && aw_addr_reg == count_offset)
        begin
            count_reg <= wr_count;
        end
        else if (expire && ctl_reg.reload)
        begin
            count_reg <= start_reg;
        end
        else if (ticking && count_reg != word_zero)
        begin
            count_reg <= count_reg - word_one;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            expiry_irq <= 1'b0;
        end
        else
        begin
            expiry_irq <= expire
                          && !(ctl_write && !resume);
        end
    end

    generate
        for (gi = 0; gi < soft_irq_count; gi++)
        begin : g_soft
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    soft_irq[gi] <= 1'b0;
                end
                else
                begin
                    soft_irq[gi] <= wr_go && aw_addr_reg == soft_irq_offset
                                    && w_strb_reg[0] && w_data_reg[gi];
                end
            end
        end
    endgenerate

    property pause_holds_p;
        @(posedge aclk) disable iff (!aresetn)
        (ctl_reg.pause && !wr_go) |=> $stable(count_reg);
    endproperty
    pause_freeze_a: assert property (pause_holds_p)
        else $error("counter moved while paused");

    debug_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_reg.debug_pause_enable && freeze_sync_reg && !wr_go) |=> $stable(count_reg))
        else $error("counter moved under debug freeze");

    count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ticking && !wr_go && count_reg > word_one) |=> count_reg == $past(count_reg) - word_one)
        else $error("counter did not decrement");

    sequence expire_s;
        ticking && count_reg == word_one && !wr_go;
    endsequence
    expiry_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        expire_s |=> expiry_irq ##1 !expiry_irq)
        else $error("expiry pulse wrong");

    expiry_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        expiry_irq |-> $past(expire))
        else $error("expiry without one-to-zero");

    oneshot_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (expire_s and !ctl_reg.reload) |=> !ctl_reg.run && count_reg == word_zero)
        else $error("one-shot did not stop");

    reload_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (expire_s and ctl_reg.reload) |=> count_reg == $past(start_reg))
        else $error("reload value wrong");

    disable_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_reg.enable && !wr_go) |=> count_reg == word_zero && !ctl_reg.run)
        else $error("disabled timer not cleared");

    soft_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == soft_irq_offset)
        |=> s_axi_rdata == word_zero)
        else $error("soft interrupt register read not zero");

    run_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_write && run_write && !ctl_reg.run) |=> count_reg == $past(start_reg))
        else $error("start value not loaded on run");

    zero_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_write && !ctl_reg.run && start_reg == word_zero) |=> !ctl_reg.run)
        else $error("run set with zero start value");

    resume_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (resume && frozen) |=> $stable(count_reg))
        else $error("counter moved on resume write");

    soft_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && aw_addr_reg == soft_irq_offset && w_strb_reg[0])
        |=> soft_irq == $past(w_data_reg[soft_irq_count-1:0]))
        else $error("soft interrupt pulse wrong");
endmodule

// file: verif/low_power_down_timer_control_tb.sv
`timescale 1ns/1ps
module low_power_down_timer_control_tb;
    import down_timer_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic [3:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [3:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        debug_freeze;
    logic        expiry_irq;
    logic [3:0]  soft_irq;
    logic [3:0]  soft_prev;
    logic        exp_prev;
    int          num_errors;
    int          n_checks;
    int          exp_cnt;
    int          soft_cnt [4];
    int          snap [4];
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0]  rs;

    down_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .debug_freeze(debug_freeze), .expiry_irq(expiry_irq),
        .soft_irq(soft_irq));

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50 && bvalid !== 1'b1)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            n++;
        end
        if (n >= 50)
            check(32'h0, 32'h1);
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [3:0] ad, output logic [31:0] d);
        int n;
        n = 0;
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50 && rvalid !== 1'b1)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            n++;
        end
        if (n >= 50)
            check(32'h0, 32'h1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    always @(posedge aclk)
    begin
        exp_prev <= expiry_irq;
        soft_prev <= soft_irq;
        if (expiry_irq === 1'b1)
            exp_cnt++;
        for (int i = 0; i < 4; i++)
            if (soft_irq[i] === 1'b1)
                soft_cnt[i]++;
        if ((expiry_irq & exp_prev) === 1'b1 || (soft_irq & soft_prev) !== 4'h0)
            check(32'h1, 32'h0);
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        complete_run();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, debug_freeze} = 7'h00;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++)
        begin
            rd(4'(4 * i), a);
            check(a, word_zero);
            check({30'h0, rs}, {30'h0, resp_okay});
        end
        $display("test reset_values done");
        for (int i = 0; i < soft_irq_count; i++)
        begin
            snap = soft_cnt;
            wr(soft_irq_offset, 32'h1 << i);
            repeat (2) @(posedge aclk);
            for (int j = 0; j < 4; j++)
                check(32'(soft_cnt[j] - snap[j]), {31'h0, j == i});
        end
        snap = soft_cnt;
        wr(soft_irq_offset, 32'h0);
        repeat (2) @(posedge aclk);
        check(32'(soft_cnt[0] + soft_cnt[1] + soft_cnt[2] + soft_cnt[3]),
              32'(snap[0] + snap[1] + snap[2] + snap[3]));
        wr(soft_irq_offset, 32'hF);
        rd(soft_irq_offset, a);
        check(a, word_zero);
        wr(4'h1, word_one);
        check({30'h0, rs}, {30'h0, resp_slverr});
        rd(4'h5, a);
        check({30'h0, rs}, {30'h0, resp_slverr});
        $display("test soft_irq done");
        wr(control_offset, 32'h5);
        rd(control_offset, a);
        check(a, 32'h1);
        wr(start_offset, 32'h5);
        check({30'h0, rs}, {30'h0, resp_okay});
        snap[0] = exp_cnt;
        wr(control_offset, 32'h5);
        repeat (20) @(posedge aclk);
        rd(control_offset, a);
        check(a, 32'h1);
        rd(count_offset, a);
        check(a, word_zero);
        check(32'(exp_cnt - snap[0]), 32'h1);
        $display("test one_shot done");
        snap[1] = exp_cnt;
        wr(start_offset, 32'h10);
        wr(control_offset, 32'h7);
        wr(start_offset, 32'h100);
        rd(count_offset, a);
        check({31'h0, a <= 32'h10}, 32'h1);
        repeat (30) @(posedge aclk);
        rd(count_offset, a);
        check({31'h0, a > 32'h10}, 32'h1);
        rd(control_offset, a);
        check(a, 32'h7);
        check(32'(exp_cnt - snap[1]), 32'h1);
        $display("test periodic done");
        wr(control_offset, 32'h17);
        wr(count_offset, 32'h80);
        rd(count_offset, a);
        repeat (10) @(posedge aclk);
        rd(count_offset, b);
        check(a, 32'h80);
        check(b, a);
        wr(control_offset, 32'hF);
        debug_freeze <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(count_offset, a);
        check({31'h0, a < 32'h80 && a > 32'h60}, 32'h1);
        repeat (10) @(posedge aclk);
        rd(count_offset, b);
        check(b, a);
        wr(control_offset, 32'h7);
        rd(count_offset, a);
        repeat (10) @(posedge aclk);
        rd(count_offset, b);
        check({31'h0, a - b >= 32'hA && a - b <= 32'h1E}, 32'h1);
        debug_freeze <= 1'b0;
        $display("test pause done");
        wr(control_offset, 32'h17);
        wr(count_offset, word_one);
        snap[0] = exp_cnt;
        wr(control_offset, 32'h1);
        rd(count_offset, a);
        check(a, word_zero);
        repeat (5) @(posedge aclk);
        check(32'(exp_cnt), 32'(snap[0]));
        wstrb <= 4'h2;
        wr(count_offset, 32'hAAAA_AAAA);
        wstrb <= 4'hF;
        rd(count_offset, a);
        check(a, 32'h0000_AA00);
        wr(start_offset, 32'h55);
        wr(control_offset, 32'h1B);
        wr(control_offset, 32'h0);
        rd(control_offset, a);
        check(a, word_zero);
        rd(start_offset, a);
        check(a, word_zero);
        $display("test stop_disable done");
        wr(control_offset, 32'h1);
        wr(start_offset, 32'h40);
        wr(control_offset, 32'h7);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(control_offset, a);
        check(a, word_zero);
        rd(count_offset, a);
        check(a, word_zero);
        rd(start_offset, a);
        check(a, word_zero);
        $display("test mid_reset done");
        complete_run();
    end
endmodule
